/* fault_seq_pkg.sv */
package fault_seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned HICCUP_OFF_MS   = 55;
  localparam int unsigned HICCUP_OFF_CYC  = (CLK_HZ / 1000) * HICCUP_OFF_MS;
  localparam int unsigned OC_COUNT_LIMIT  = 32;
  localparam int unsigned MIN_ON_NS       = 200;
  localparam int unsigned MIN_ON_CYC      = (MIN_ON_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SOFTSTART_US    = 1000;
  localparam int unsigned SOFTSTART_CYC   = (CLK_HZ / 1_000_000) * SOFTSTART_US;
  localparam int unsigned TMR_W           = 21;
  localparam int unsigned OCC_W           = 6;
  localparam int unsigned MON_W           = 4;
  localparam int unsigned NCH             = 2;

  localparam logic [OCC_W-1:0] OCC_LIMIT  = OCC_W'(OC_COUNT_LIMIT);
  localparam logic [MON_W-1:0] MIN_ON     = MON_W'(MIN_ON_CYC);

  // ----------------------------------------------------------------
  // comparator bundle per channel
  // ----------------------------------------------------------------
  typedef struct packed {
    logic avg_oc;     // average current above set point
    logic peak_oc;    // first level peak limit tripped
    logic peak_hic;   // second level peak limit tripped
    logic neg_oc;     // negative peak limit tripped
    logic overvoltage_protection;        // output above overvoltage point
    logic in_reg;     // output inside regulation window
  } chan_cmp_t;

  localparam int unsigned CMP_W = $bits(chan_cmp_t);

  typedef struct packed {
    logic high_side;
    logic low_side;
  } gate_t;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_INIT   = 3'b001,
    ST_SOFT   = 3'b010,
    ST_RUN    = 3'b011,
    ST_HICCUP = 3'b100,
    ST_OTP    = 3'b101
  } seq_state_t;

endpackage : fault_seq_pkg

/* buck_protection_fault_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// - undervoltage lockout resets logic, disables controller
// - regulation flag low during undervoltage lockout
// - rail good at rising, lost at falling
// - mode pin sampled once at init
// - constant-current mode never shuts down on average overcurrent
// - 32 overcurrent cycles give 55ms off
// - peak trip ends high side pulse
// - minimum on time masks peak limit
// - second level peak gives 55ms off
// - negative peak: low off, high on
// - overvoltage event above 114 percent
// - overvoltage holds high off, low on, except while a negative peak holds high on, low off
// - overvoltage clear resumes without restart
// - overvoltage flag pin high on trip
// - over-temperature shuts controller down
// - restart below 145C through soft-start
// - thermal protection ignored while disabled
// - regulation flag drops three clocks after in-regulation falls
module buck_protection_fault_sequencer
  import fault_seq_pkg::*;
(
  input  wire logic                   clk_sys_i,         // 20 MHz device clock
  input  wire logic                   rst_b_i,           // power-on reset, active low
  input  wire logic                   input_undervoltage_lockout_i,            // input below 3.2 V
  input  wire logic                   rail_above_rise_i, // internal 5 V rail above 4 V
  input  wire logic                   rail_below_fall_i, // internal 5 V rail below 3.5 V
  input  wire logic                   enable_i,          // controller enable
  input  wire logic                   mode_pin_low_i,    // mode pin below 0.3 V
  input  wire logic                   temp_hot_i,        // die at or above 160 C
  input  wire logic                   temp_cool_i,       // die below 145 C
  input  wire logic [NCH-1:0]         pwm_i,             // modulator pulse request per channel
  input  wire logic [NCH-1:0]         cycle_start_i,     // switching cycle start pulse
  input  wire chan_cmp_t [NCH-1:0]    cmp_i,             // per channel comparators
  output logic      [NCH-1:0]         high_side_switch_o, // high side gate command
  output logic      [NCH-1:0]         low_side_switch_o,  // low side gate command
  output logic                        output_in_regulation_flag_o, // channel one in regulation
  output logic                        overvoltage_flag_pin_o, // overvoltage tripped
  output logic                        internal_5v_rail_good_o, // rail good, bias may be applied
  output logic                        hiccup_mode_o,     // latched hiccup protection mode
  output logic                        soft_start_o       // soft-start in progress
);

  // ----------------------------------------------------------------
  // synchronizers
  // ----------------------------------------------------------------
  localparam int unsigned SYN_W = 7 + 3 * NCH + NCH * CMP_W;

  logic [SYN_W-1:0] raw_in;
  logic [SYN_W-1:0] meta_r;
  logic [SYN_W-1:0] syn_r;

  assign raw_in = {input_undervoltage_lockout_i, rail_above_rise_i, rail_below_fall_i, enable_i, mode_pin_low_i,
                   temp_hot_i, temp_cool_i, pwm_i, cycle_start_i, {NCH{1'b0}}, cmp_i};

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= '0;
      syn_r  <= '0;
    end
    else
    begin
      meta_r <= raw_in;
      syn_r  <= meta_r;
    end
  end

  wire              s_input_undervoltage_lockout   = syn_r[SYN_W-1];
  wire              s_rise   = syn_r[SYN_W-2];
  wire              s_fall   = syn_r[SYN_W-3];
  wire              s_en     = syn_r[SYN_W-4];
  wire              s_mlow   = syn_r[SYN_W-5];
  wire              s_hot    = syn_r[SYN_W-6];
  wire              s_cool   = syn_r[SYN_W-7];
  wire [NCH-1:0]    s_pwm    = syn_r[NCH*CMP_W+3*NCH-1 -: NCH];
  wire [NCH-1:0]    s_cyc    = syn_r[NCH*CMP_W+2*NCH-1 -: NCH];
  chan_cmp_t [NCH-1:0] s_cmp;
  assign s_cmp = syn_r[NCH*CMP_W-1:0];

  // ----------------------------------------------------------------
  // rail power-on with hysteresis
  // ----------------------------------------------------------------
  logic rail_good_r;
  wire  rail_good_nxt = s_rise ? 1'b1 : (s_fall ? 1'b0 : rail_good_r);

  // lockout acts like a synchronous reset of sequencer and channel state; the mode latch holds
  wire lockout = s_input_undervoltage_lockout | ~rail_good_r;
  wire active  = s_en & ~lockout;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  seq_state_t       state_r;
  seq_state_t       state_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic             hiccup_r;
  logic [NCH-1:0]   ov_r;
  logic [OCC_W-1:0] occ_r [NCH];

  wire [NCH-1:0] hic_trip;
  wire [NCH-1:0] oc_trip;

  // thermal input only looked at while the controller runs
  wire otp_trip = s_hot & (state_r != ST_OFF) & (state_r != ST_OTP);

  always_comb
  begin
    state_nxt = state_r;
    tmr_nxt   = tmr_r;
    unique case (state_r)
      ST_OFF:
      begin
        tmr_nxt = '0;
        if (active)
          state_nxt = ST_INIT;
      end
      ST_INIT:
      begin
        tmr_nxt   = '0;
        state_nxt = ST_SOFT;
      end
      ST_SOFT:
      begin
        tmr_nxt = tmr_r + TMR_W'(1);
        if (tmr_r == TMR_W'(SOFTSTART_CYC - 1))
          state_nxt = ST_RUN;
      end
      ST_RUN:
        tmr_nxt = '0;
      ST_HICCUP:
      begin
        tmr_nxt = tmr_r + TMR_W'(1);
        if (tmr_r == TMR_W'(HICCUP_OFF_CYC - 1))
        begin
          state_nxt = ST_SOFT;
          tmr_nxt   = '0;
        end
      end
      ST_OTP:
      begin
        tmr_nxt = '0;
        if (s_cool)
          state_nxt = ST_SOFT;
      end
      default:
        state_nxt = ST_OFF;
    endcase
    if ((state_r == ST_SOFT || state_r == ST_RUN) && ((|hic_trip) || (|oc_trip)))
    begin
      state_nxt = ST_HICCUP;
      tmr_nxt   = '0;
    end
    if (otp_trip)
      state_nxt = ST_OTP;
    if (!active)
      state_nxt = ST_OFF;
  end

  wire switching = (state_r == ST_SOFT) || (state_r == ST_RUN);

  // ----------------------------------------------------------------
  // per channel gating
  // ----------------------------------------------------------------
  logic [MON_W-1:0] on_cnt_r [NCH];
  logic [NCH-1:0]   pk_cut_r;
  logic [NCH-1:0]   neg_r;
  logic [NCH-1:0]   hs_nxt;
  logic [NCH-1:0]   ls_nxt;

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    // a new cycle starts clean: last cycle's cut, latch and count must not leak in
    wire [MON_W-1:0] on_eff  = s_cyc[c] ? '0 : on_cnt_r[c];
    wire             cut_old = pk_cut_r[c] & ~s_cyc[c];
    wire             neg_old = neg_r[c] & ~s_cyc[c];
    wire             blanked = s_pwm[c] & (on_eff < MIN_ON);
    wire             cut_now = s_cmp[c].peak_oc & ~blanked;

    // count only in hiccup mode; the trip cycle restarts the count
    wire             occ_step = switching & hiccup_r & s_cmp[c].avg_oc & ~oc_trip[c];
    wire [OCC_W-1:0] occ_nxt  = occ_step ? occ_r[c] + OCC_W'(1) : '0;
    wire [MON_W-1:0] on_start = (switching & s_pwm[c]) ? MON_W'(1) : '0;

    // constant-current mode regulates in the loop, no shutdown on average overcurrent
    assign oc_trip[c]  = hiccup_r & s_cmp[c].avg_oc & s_cyc[c]
                         & (occ_r[c] == OCC_LIMIT - OCC_W'(1));
    assign hic_trip[c] = s_cmp[c].peak_hic;

    always_comb
    begin
      hs_nxt[c] = 1'b0;
      ls_nxt[c] = 1'b0;
      if (switching)
      begin
        if (ov_r[c])
        begin
          hs_nxt[c] = 1'b0;
          ls_nxt[c] = 1'b1;
        end
        else
        begin
          hs_nxt[c] = s_pwm[c] & ~cut_old & ~cut_now;
          ls_nxt[c] = ~hs_nxt[c];
        end
        if (s_cmp[c].neg_oc | neg_old)
        begin
          hs_nxt[c] = 1'b1;
          ls_nxt[c] = 1'b0;
        end
      end
    end

    // ----------------------------------------------------------------
    // per cycle bookkeeping
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        on_cnt_r[c] <= '0;
        pk_cut_r[c] <= 1'b0;
        neg_r[c]    <= 1'b0;
        occ_r[c]    <= '0;
        ov_r[c]     <= 1'b0;
      end
      else if (s_cyc[c] || !switching)
      begin
        on_cnt_r[c] <= on_start;
        pk_cut_r[c] <= 1'b0;
        neg_r[c]    <= switching & s_cmp[c].neg_oc;
        occ_r[c]    <= occ_nxt;
        ov_r[c]     <= switching & s_cmp[c].overvoltage_protection;
      end
      else
      begin
        if (s_pwm[c] && on_cnt_r[c] != {MON_W{1'b1}})
          on_cnt_r[c] <= on_cnt_r[c] + MON_W'(1);
        pk_cut_r[c] <= pk_cut_r[c] | cut_now;
        neg_r[c]    <= neg_r[c] | s_cmp[c].neg_oc;
        ov_r[c]     <= s_cmp[c].overvoltage_protection;
      end
    end
  end

  // ----------------------------------------------------------------
  // state, mode latch and outputs
  // ----------------------------------------------------------------
  // mode is captured from a clocked sample in init, never at reset
  wire hiccup_nxt = (state_r == ST_INIT) ? ~s_mlow : hiccup_r;
  wire pg_nxt     = ~lockout & s_en & (state_r == ST_RUN) & s_cmp[0].in_reg;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r     <= ST_OFF;
      tmr_r       <= '0;
      rail_good_r <= 1'b0;
      hiccup_r    <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      tmr_r       <= tmr_nxt;
      rail_good_r <= rail_good_nxt;
      hiccup_r    <= hiccup_nxt;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // outputs take next-state values so no pin waits an extra cycle, except the overvoltage flag, taken from registered ov_r
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      high_side_switch_o          <= '0;
      low_side_switch_o           <= '0;
      output_in_regulation_flag_o <= 1'b0;
      overvoltage_flag_pin_o      <= 1'b0;
      internal_5v_rail_good_o     <= 1'b0;
      hiccup_mode_o               <= 1'b0;
      soft_start_o                <= 1'b0;
    end
    else
    begin
      high_side_switch_o          <= hs_nxt;
      low_side_switch_o           <= ls_nxt;
      output_in_regulation_flag_o <= pg_nxt;
      overvoltage_flag_pin_o      <= |ov_r;
      internal_5v_rail_good_o     <= rail_good_nxt;
      hiccup_mode_o               <= hiccup_nxt;
      soft_start_o                <= (state_nxt == ST_SOFT);
    end
  end

endmodule : buck_protection_fault_sequencer

/* fault_seq_chk_asserts.sv */
`timescale 1ns/1ps
module fault_seq_chk
  import fault_seq_pkg::*;
(
  input wire logic                clk_sys_i,                   // clock
  input wire logic                rst_b_i,                     // reset
  input wire logic                input_undervoltage_lockout_i,                      // lockout
  input wire logic                rail_above_rise_i,           // rail rising
  input wire logic                rail_below_fall_i,           // rail falling
  input wire logic                temp_hot_i,                  // die hot
  input wire chan_cmp_t [NCH-1:0] cmp_i,                       // comparators
  input wire logic [NCH-1:0]      high_side_switch_o,          // high gates
  input wire logic [NCH-1:0]      low_side_switch_o,           // low gates
  input wire logic                output_in_regulation_flag_o, // in regulation
  input wire logic                overvoltage_flag_pin_o,      // ov flag
  input wire logic                internal_5v_rail_good_o,     // rail good
  input wire logic                hiccup_mode_o,               // mode
  input wire logic                soft_start_o                 // soft-start
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  wire logic [NCH-1:0] gates_w = high_side_switch_o | low_side_switch_o;
  wire logic           ovp_w   = cmp_i[0].overvoltage_protection | cmp_i[1].overvoltage_protection;

  property p_input_undervoltage_lockout; input_undervoltage_lockout_i [*4] |=> !soft_start_o && gates_w == '0; endproperty
  a_input_undervoltage_lockout: assert property (p_input_undervoltage_lockout) else $error("switching in lockout");
  property p_input_undervoltage_lockout_flag; input_undervoltage_lockout_i [*3] |=> !output_in_regulation_flag_o; endproperty
  a_input_undervoltage_lockout_flag: assert property (p_input_undervoltage_lockout_flag) else $error("flag high in lockout");
  property p_rail_fall; rail_below_fall_i [*3] |=> !internal_5v_rail_good_o; endproperty
  a_rail_fall: assert property (p_rail_fall) else $error("rail good below fall");
  property p_rail_hyst;
    $changed(internal_5v_rail_good_o) |-> $past(rail_above_rise_i, 3) || $past(rail_below_fall_i, 3);
  endproperty
  a_rail_hyst: assert property (p_rail_hyst) else $error("rail good moved inside band");
  property p_ov_flag; $rose(overvoltage_flag_pin_o) |-> $past(ovp_w, 4); endproperty
  a_ov_flag: assert property (p_ov_flag) else $error("ov flag without cause");
  property p_reg_drop; $fell(cmp_i[0].in_reg) |-> ##3 !output_in_regulation_flag_o; endproperty
  a_reg_drop: assert property (p_reg_drop) else $error("flag late to drop");
  property p_hot; temp_hot_i [*5] |=> gates_w == '0; endproperty
  a_hot: assert property (p_hot) else $error("switching while hot");
  property p_peak_hic; cmp_i[0].peak_hic [*5] |=> gates_w == '0; endproperty
  a_peak_hic: assert property (p_peak_hic) else $error("switching after second peak");
  property p_mode; $changed(hiccup_mode_o) |-> ##[0:1] soft_start_o; endproperty
  a_mode: assert property (p_mode) else $error("mode moved outside start");

  c_soft: cover property ($rose(soft_start_o));
  c_ov: cover property ($rose(overvoltage_flag_pin_o));
  c_hic: cover property ($rose(hiccup_mode_o));
endmodule : fault_seq_chk

bind buck_protection_fault_sequencer fault_seq_chk u_chk (.*);

/* power_stage_model.sv */
`timescale 1ns/1ps
module power_stage_model
  import fault_seq_pkg::*;
#(
  parameter int PER = 20
)
(
  input  wire logic      clk_sys_i,     // device clock
  input  wire logic      rst_b_i,       // reset, active low
  input  wire logic      rail_good_i,   // rail good from device
  output logic [NCH-1:0] pwm_o,         // high side requests
  output logic [NCH-1:0] cycle_start_o, // cycle start pulses
  output logic           ext_bias_o     // external bias applied
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  assign cnt_nxt       = (cnt_r == 8'(PER - 1)) ? 8'h0 : cnt_r + 8'h1;
  assign pwm_o         = {NCH{cnt_r < 8'(PER / 2)}};
  assign cycle_start_o = {NCH{cnt_r == 8'h0}};
  assign ext_bias_o    = rail_good_i; // bias held off until rail good
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i)
      cnt_r <= 8'h0;
    else
      cnt_r <= cnt_nxt;
endmodule : power_stage_model

/* buck_protection_fault_sequencer_bench.sv */
`timescale 1ns/1ps
module buck_protection_fault_sequencer_bench;
  import fault_seq_pkg::*;
  logic                clk, rst_b, input_undervoltage_lockout, above, below, en, mode_low, hot, cool;
  logic                flag, ovf, rgood, hic, ss, bias;
  logic [NCH-1:0]      pwm, cs, hs, ls;
  chan_cmp_t [NCH-1:0] cmp;
  int                  fail_count = 0;
  int                  checks = 0;
  int                  n;

  buck_protection_fault_sequencer dut (.clk_sys_i(clk), .rst_b_i(rst_b), .input_undervoltage_lockout_i(input_undervoltage_lockout),
    .rail_above_rise_i(above), .rail_below_fall_i(below), .enable_i(en), .mode_pin_low_i(mode_low),
    .temp_hot_i(hot), .temp_cool_i(cool), .pwm_i(pwm), .cycle_start_i(cs), .cmp_i(cmp),
    .high_side_switch_o(hs), .low_side_switch_o(ls), .output_in_regulation_flag_o(flag),
    .overvoltage_flag_pin_o(ovf), .internal_5v_rail_good_o(rgood), .hiccup_mode_o(hic),
    .soft_start_o(ss));
  power_stage_model #(.PER(20)) stage (.clk_sys_i(clk), .rst_b_i(rst_b), .rail_good_i(rgood),
    .pwm_o(pwm), .cycle_start_o(cs), .ext_bias_o(bias));

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  task automatic tick_s(input int k);
    tick(k);
    #1;
  endtask : tick_s
  // align to a cycle start, then k edges in
  task automatic ofs(input int k);
    do @(posedge clk); while (!cs[0]);
    tick_s(k);
  endtask : ofs
  task automatic hs_count(output int c);
    ofs(0);
    c = 0;
    repeat (20)
    begin
      tick_s(1);
      c += hs[0];
    end
  endtask : hs_count
  task automatic wait_ss(input logic v);
    int k;
    k = 0;
    while (ss !== v && k < 25000)
    begin
      tick_s(1);
      k++;
    end
    chk(ss, v);
  endtask : wait_ss
  task automatic close_out;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    rst_b <= 1'h0; input_undervoltage_lockout <= 1'h1; above <= 1'h0; below <= 1'h1; en <= 1'h0;
    mode_low <= 1'h1; hot <= 1'h0; cool <= 1'h1; cmp <= '0;
    tick(8);
    rst_b <= 1'h1;
    tick_s(2);
    chk({hs, ls, flag, ss, bias}, 8'h0);
    tick(1);
    above <= 1'h1; below <= 1'h0; en <= 1'h1; cmp[0].in_reg <= 1'h1;
    tick_s(10);
    chk({rgood, bias}, 8'h3);
    chk({ss, flag, hs, ls}, 8'h0);
    tick(1);
    above <= 1'h0;
    tick_s(6);
    chk(rgood, 8'h1);
    $display("end lockout");
    tick(1);
    input_undervoltage_lockout <= 1'h0;
    tick_s(6);
    chk({ss, hic}, 8'h2);
    tick(1);
    mode_low <= 1'h0;
    wait_ss(1'h0);
    chk(hic, 8'h0);
    tick_s(10);
    chk(flag, 8'h1);
    tick(1);
    cmp[0].in_reg <= 1'h0;
    tick_s(3);
    chk(flag, 8'h0);
    hs_count(n);
    chk(8'(n), 8'ha);
    tick(1);
    cmp[0].peak_oc <= 1'h1;
    hs_count(n);
    hs_count(n);
    chk(8'(n), 8'(MIN_ON_CYC));
    tick(1);
    cmp[0].peak_oc <= 1'h0; cmp[0].neg_oc <= 1'h1;
    ofs(17);
    chk({hs[0], ls[0]}, 8'h2);
    tick(1);
    cmp[0].neg_oc <= 1'h0; cmp[0].overvoltage_protection <= 1'h1;
    ofs(7);
    ofs(7);
    chk({hs[0], ls[0], ovf}, 8'h3);
    tick(1);
    cmp[0].overvoltage_protection <= 1'h0;
    ofs(7);
    ofs(7);
    chk({hs[0], ls[0], ovf, ss}, 8'h8);
    $display("end gating");
    tick(1);
    cmp[0].avg_oc <= 1'h1;
    repeat (36) ofs(1);
    hs_count(n);
    chk(8'(n), 8'ha);
    tick(1);
    cmp[0].avg_oc <= 1'h0; cool <= 1'h0; hot <= 1'h1;
    tick_s(6);
    chk({hs, ls}, 8'h0);
    tick(1);
    hot <= 1'h0;
    tick_s(50);
    chk({hs, ls, ss}, 8'h0);
    tick(1);
    cool <= 1'h1;
    tick_s(6);
    chk({ss, hic}, 8'h2);
    wait_ss(1'h0);
    $display("end thermal");
    tick(1);
    en <= 1'h0; hot <= 1'h1; cool <= 1'h0;
    tick(10);
    hot <= 1'h0; en <= 1'h1;
    tick_s(6);
    chk({ss, hic}, 8'h3);
    wait_ss(1'h0);
    tick(1);
    cmp[0].avg_oc <= 1'h1;
    repeat (28) ofs(1);
    ofs(7);
    chk(hs[0], 8'h1);
    repeat (6) ofs(1);
    tick_s(4);
    chk({hs, ls, ss}, 8'h0);
    tick(1);
    cmp[0].avg_oc <= 1'h0; en <= 1'h0;
    tick(6);
    en <= 1'h1;
    tick_s(6);
    chk({ss, hic}, 8'h3);
    tick(1);
    cmp[0].peak_hic <= 1'h1;
    tick_s(6);
    chk({hs, ls, ss, hic}, 8'h1);
    tick_s(2000);
    chk({hs, ls, ss, hic}, 8'h1);
    $display("end hiccup");
    close_out();
  end

  initial
  begin
    #(80000 * 50);
    fail_count++;
    close_out();
  end
endmodule : buck_protection_fault_sequencer_bench
